// ==== verilog/fpp_ctrl.sv ====
`timescale 1ns/1ps
// Behaviour
// - flash is 128 pages of 32 bytes; one operation covers a page
// - page data comes from 32 consecutive ram bytes from buffer start
// - target page is address bits 11..5, low five bits zero
// - start needs nibble 0xa then byte 0x5a, together 0xa5a
// - any nibble other than 0xa keeps programming disabled
// - a valid start copies the ram buffer into the flash page
// - each operation erases the page, then programs it, with cpu_stall high throughout
// - buffer start register resets to 0x00, all bits read and write
module fpp_ctrl
    import fpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic cpu_stall,
    output logic [7:0] ram_addr,
    output logic ram_rd,
    input wire logic [7:0] ram_rdata,
    output logic flash_erase,
    output logic flash_write,
    output logic [PAGE_IDX_W-1:0] flash_page,
    output logic [BYTE_IDX_W-1:0] flash_byte,
    output logic [7:0] flash_wdata,
    output logic busy
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] buffer_start_address;
    logic [7:0] page_address_high;
    logic [2:0] page_address_low;
    logic [3:0] program_command_high;
    logic acc_done;
    fpp_state_t state;
    fpp_state_t next_state;
    logic [BYTE_IDX_W-1:0] byte_idx;
    logic [PAGE_IDX_W-1:0] page_lat;
    logic [7:0] base_lat;
    logic fetch_wait;

    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire [7:0] reg_idx = avs_address[7:0];
    // writes land at the answer edge, while the master still holds them
    wire wr_ok = avs_write && avs_byteenable[0] && acc_done;
    wire sel_cmd = reg_idx == IDX_PROGRAM_COMMAND_LOW;
    wire sel_low = reg_idx == IDX_PAGE_ADDRESS_LOW;
    wire sel_high = reg_idx == IDX_PAGE_ADDRESS_HIGH;
    wire sel_buf = reg_idx == IDX_BUFFER_START_ADDRESS;
    wire sel_stat = reg_idx == IDX_STATUS;
    wire hi_zero = avs_address[ADDR_W-1:ADDR_W-2] == 2'b00;
    wire wr_cmd = wr_ok && hi_zero && sel_cmd;
    wire wr_low = wr_ok && hi_zero && sel_low;
    wire wr_high = wr_ok && hi_zero && sel_high;
    wire wr_buf = wr_ok && hi_zero && sel_buf;
    wire unlocked = program_command_high == UNLOCK_KEY;
    wire idle = state == ST_IDLE;
    // combined 0xa5a start; other bytes ignored
    wire start = wr_cmd && unlocked && idle && (avs_writedata[7:0] == START_KEY);
    wire [7:0] low_read = {page_address_low, 1'b0, program_command_high};
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        if (!hi_zero) begin
            rd_mux = 8'h00;
        end else if (sel_low) begin
            rd_mux = low_read;
        end else if (sel_high) begin
            rd_mux = page_address_high;
        end else if (sel_buf) begin
            rd_mux = buffer_start_address;
        end else if (sel_stat) begin
            rd_mux = {7'h00, !idle};
        end
    end

    // ----------------------------------------------------------------
    // avalon slave: one wait cycle per access
    // ----------------------------------------------------------------
    wire req = (avs_read || avs_write) && !acc_done;
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            acc_done <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0;
        end else begin
            acc_done <= req;
            avs_waitrequest <= !req;
            if (req && avs_read) begin
                avs_readdata <= {24'h0, rd_mux};
            end
        end
    end

    // ----------------------------------------------------------------
    // configuration registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            buffer_start_address <= RESET_BYTE;
            page_address_high <= RESET_BYTE;
            page_address_low <= RESET_LOW3;
            program_command_high <= RESET_NIBBLE;
        end else begin
            if (wr_buf && idle) begin
                buffer_start_address <= avs_writedata[7:0];
            end
            if (wr_high && idle) begin
                page_address_high <= avs_writedata[7:0];
            end
            if (wr_low && idle) begin
                page_address_low <= avs_writedata[7:5];
                program_command_high <= avs_writedata[3:0];
            end else if (start) begin
                program_command_high <= RESET_NIBBLE;
            end
        end
    end

    // ----------------------------------------------------------------
    // erase and program timing
    // ----------------------------------------------------------------
    wire tmr_load = start || (state == ST_FETCH && fetch_wait);
    wire [TMR_W-1:0] tmr_count = start ? TMR_W'(ERASE_CYCLES) : TMR_W'(PROG_CYCLES);
    wire tmr_expired;
    fpp_timer u_timer (
        .core_clk(core_clk),
        .rst(rst),
        .load(tmr_load),
        .count(tmr_count),
        .expired(tmr_expired)
    );

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    wire last_byte = byte_idx == LAST_BYTE;
    // page index reaches the flash port with the first erase cycle
    wire [PAGE_IDX_W-1:0] next_page =
        start ? {page_address_high[3:0], page_address_low} : page_lat;
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = ST_ERASE;
                end
            end
            ST_ERASE: begin
                if (tmr_expired) begin
                    next_state = ST_FETCH;
                end
            end
            ST_FETCH: begin
                if (fetch_wait) begin
                    next_state = ST_PROG;
                end
            end
            ST_PROG: begin
                if (tmr_expired) begin
                    next_state = last_byte ? ST_DONE : ST_FETCH;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= ST_IDLE;
            byte_idx <= '0;
            page_lat <= '0;
            base_lat <= 8'h00;
            fetch_wait <= 1'b0;
        end else begin
            state <= next_state;
            fetch_wait <= (state == ST_FETCH) && !fetch_wait;
            if (start) begin
                page_lat <= next_page;
                base_lat <= buffer_start_address;
                byte_idx <= '0;
            end else if (state == ST_PROG && tmr_expired) begin
                byte_idx <= byte_idx + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // flash and ram ports
    // ----------------------------------------------------------------
    wire [7:0] next_ram_addr = base_lat + {3'b000, byte_idx};
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ram_addr <= 8'h00;
            ram_rd <= 1'b0;
            flash_erase <= 1'b0;
            flash_write <= 1'b0;
            flash_page <= '0;
            flash_byte <= '0;
            flash_wdata <= 8'h00;
            cpu_stall <= 1'b0;
            busy <= 1'b0;
        end else begin
            ram_addr <= next_ram_addr;
            ram_rd <= next_state == ST_FETCH;
            flash_erase <= next_state == ST_ERASE;
            flash_write <= next_state == ST_PROG;
            flash_page <= next_page;
            flash_byte <= byte_idx;
            if (state == ST_FETCH && fetch_wait) begin
                flash_wdata <= ram_rdata;
            end
            cpu_stall <= next_state != ST_IDLE;
            busy <= next_state != ST_IDLE;
        end
    end
endmodule : fpp_ctrl

// ==== inc/fpp_pkg.sv ====
package fpp_pkg;
    // ----------------------------------------------------------------
    // register offsets (byte addresses, printed offsets not word aligned)
    // ----------------------------------------------------------------
    localparam logic [7:0] IDX_PROGRAM_COMMAND_LOW = 8'h94;
    localparam logic [7:0] IDX_PAGE_ADDRESS_LOW = 8'h95;
    localparam logic [7:0] IDX_PAGE_ADDRESS_HIGH = 8'h96;
    localparam logic [7:0] IDX_BUFFER_START_ADDRESS = 8'h97;
    localparam logic [7:0] IDX_STATUS = 8'h98;
    localparam int ADDR_W = 10;
    // ----------------------------------------------------------------
    // fields and values
    // ----------------------------------------------------------------
    localparam logic [3:0] UNLOCK_KEY = 4'ha;
    localparam logic [7:0] START_KEY = 8'h5a;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [3:0] RESET_NIBBLE = 4'h0;
    localparam logic [2:0] RESET_LOW3 = 3'h0;
    localparam int PAGE_BYTES = 32;
    localparam int PAGE_COUNT = 128;
    localparam int BYTE_IDX_W = 5;
    localparam int PAGE_IDX_W = 7;
    localparam logic [4:0] LAST_BYTE = 5'h1f;
    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int ERASE_TIME_US = 100;
    localparam int ERASE_CYCLES = ERASE_TIME_US * CLK_MHZ;
    localparam int PROG_TIME_US = 2;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
    localparam int TMR_W = 16;
    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ERASE = 5'b00010,
        ST_FETCH = 5'b00100,
        ST_PROG = 5'b01000,
        ST_DONE = 5'b10000
    } fpp_state_t;
endpackage : fpp_pkg

// ==== verilog/fpp_timer.sv ====
`timescale 1ns/1ps
module fpp_timer
    import fpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [TMR_W-1:0] count,
    output logic expired
);
    // ----------------------------------------------------------------
    // one-shot down counter
    // ----------------------------------------------------------------
    logic [TMR_W-1:0] remain;
    logic running;
    wire last_tick = running && (remain == {{(TMR_W-1){1'b0}}, 1'b1});

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            remain <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else begin
            expired <= last_tick;
            if (load) begin
                remain <= count;
                running <= 1'b1;
            end else if (running) begin
                remain <= remain - 1'b1;
                running <= !last_tick;
            end
        end
    end
endmodule : fpp_timer

// ==== test/fpp_ctrl_chk.sv ====
`timescale 1ns/1ps
module fpp_ctrl_chk
    import fpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic cpu_stall,
    input wire logic ram_rd,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [PAGE_IDX_W-1:0] flash_page,
    input wire logic [BYTE_IDX_W-1:0] flash_byte,
    input wire logic [7:0] flash_wdata,
    input wire logic busy
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    wire logic cmd_go = avs_write && avs_address == {2'b00, IDX_PROGRAM_COMMAND_LOW}
        && avs_writedata[7:0] == START_KEY;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_erase_begin;
        ##[0:2] flash_erase;
    endsequence
    sequence s_erase_hold;
        flash_erase [*8];
    endsequence
    property p_stall; cpu_stall == busy; endproperty
    a_stall: assert property (p_stall) else $error("stall differs from busy");
    property p_answer; $rose(avs_read || avs_write) |=> !avs_waitrequest; endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("answer too long");
    property p_erase_first; $rose(busy) |-> s_erase_begin; endproperty
    a_erase_first: assert property (p_erase_first) else $error("no erase");
    property p_erase_len; $rose(flash_erase) |-> s_erase_hold; endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase short");
    property p_excl; !(flash_erase && flash_write); endproperty
    a_excl: assert property (p_excl) else $error("erase with write");
    property p_ops_busy; (flash_erase || flash_write || ram_rd) |-> busy; endproperty
    a_ops_busy: assert property (p_ops_busy) else $error("op while idle");
    property p_start;
        $rose(busy) |-> ($past(cmd_go, 2) || $past(cmd_go, 3) || $past(cmd_go, 4));
    endproperty
    a_start: assert property (p_start) else $error("start without command");
    property p_wr_stable;
        flash_write && $past(flash_write) |-> $stable({flash_page, flash_byte, flash_wdata});
    endproperty
    a_wr_stable: assert property (p_wr_stable) else $error("write data moved");
    property p_page_hold; busy && $past(busy) |-> $stable(flash_page); endproperty
    a_page_hold: assert property (p_page_hold) else $error("page moved");
endmodule : fpp_ctrl_chk

// ==== test/fpp_mem_model.sv ====
`timescale 1ns/1ps
module fpp_mem_model
    import fpp_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] ram_addr,
    input wire logic ram_rd,
    output logic [7:0] ram_rdata,
    input wire logic flash_erase,
    input wire logic flash_write,
    input wire logic [PAGE_IDX_W-1:0] flash_page,
    input wire logic [BYTE_IDX_W-1:0] flash_byte,
    input wire logic [7:0] flash_wdata
);
    logic [7:0] ram [256];
    logic [7:0] rom [PAGE_COUNT*PAGE_BYTES];
    logic wr_q = 1'b0;
    // unselected ram shows inverted data
    assign ram_rdata = ram_rd ? ram[ram_addr] : ~ram[ram_addr];
    // programming only clears bits, so a missing erase shows
    always @(posedge core_clk) begin
        wr_q <= flash_write;
        if (flash_erase) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                rom[{flash_page, 5'(i)}] <= 8'hff;
            end
        end
        if (flash_write && !wr_q) begin
            rom[{flash_page, flash_byte}] <= rom[{flash_page, flash_byte}] & flash_wdata;
        end
    end
endmodule : fpp_mem_model

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top
    import fpp_pkg::*;
();
    logic core_clk = 0;
    logic rst = 1;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic cpu_stall;
    logic [7:0] ram_addr;
    logic ram_rd;
    logic [7:0] ram_rdata;
    logic flash_erase;
    logic flash_write;
    logic [PAGE_IDX_W-1:0] flash_page;
    logic [BYTE_IDX_W-1:0] flash_byte;
    logic [7:0] flash_wdata;
    logic busy;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    int wd_start = 0;
    localparam int WD_LIMIT = ERASE_CYCLES + PAGE_BYTES * (PROG_CYCLES + 8);
    logic [7:0] ex [32];
    always #20 core_clk = ~core_clk;
    fpp_ctrl dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .ram_addr(ram_addr),
        .ram_rd(ram_rd), .ram_rdata(ram_rdata), .flash_erase(flash_erase),
        .flash_write(flash_write), .flash_page(flash_page), .flash_byte(flash_byte),
        .flash_wdata(flash_wdata), .busy(busy));
    fpp_mem_model mem (.core_clk(core_clk), .ram_addr(ram_addr), .ram_rd(ram_rd),
        .ram_rdata(ram_rdata), .flash_erase(flash_erase), .flash_write(flash_write),
        .flash_page(flash_page), .flash_byte(flash_byte), .flash_wdata(flash_wdata));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        @(posedge core_clk);
        avs_address <= {2'b00, a};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 0;
        avs_write <= 0;
    endtask : bus
    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (busy !== lvl && n < 9000) begin
            @(posedge core_clk);
            n++;
        end
        chk({7'h0, busy}, {7'h0, lvl}, "busy");
        chk({7'h0, cpu_stall}, {7'h0, lvl}, "stall");
    endtask : wait_busy
    function automatic logic [7:0] low_of(input logic [15:0] fa, input logic [3:0] nib);
        return {fa[7:5], 1'b0, nib};
    endfunction : low_of
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 40000) begin
            mismatches++;
            summarize();
        end
    end
    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        logic [7:0] q;
        logic [7:0] bs;
        logic [15:0] fa;
        void'($urandom(32'hf27c));
        repeat (6) @(posedge core_clk);
        rst <= 0;
        for (int a = 8'h95; a <= 8'h99; a++) begin
            bus(0, 8'(a), 8'h00, q);
            chk(q, RESET_BYTE, "reset value");
        end
        bs = 8'($urandom);
        bus(1, IDX_BUFFER_START_ADDRESS, bs, q);
        bus(0, IDX_BUFFER_START_ADDRESS, 8'h00, q);
        chk(q, bs, "buffer start rw");
        $display("registers done");
        for (int n = 0; n < 16; n++) begin
            bus(1, IDX_PAGE_ADDRESS_LOW, {4'h0, 4'(n)}, q);
            bus(1, IDX_PROGRAM_COMMAND_LOW, (n == 10) ? 8'h33 : START_KEY, q);
            repeat (4) @(posedge core_clk);
            chk({7'h0, busy}, 8'h00, "false start");
        end
        $display("refusals done");
        for (int k = 0; k < 2; k++) begin
            fa = {4'($urandom), 7'($urandom_range(126, 1)), 5'h1f};
            bs = 8'($urandom);
            for (int i = 0; i < 32; i++) begin
                ex[i] = 8'($urandom);
                mem.ram[8'(bs + i)] = ex[i];
            end
            bus(1, IDX_BUFFER_START_ADDRESS, bs, q);
            bus(1, IDX_PAGE_ADDRESS_HIGH, fa[15:8], q);
            bus(1, IDX_PAGE_ADDRESS_LOW, fa[7:0] & 8'he0 | {4'h0, UNLOCK_KEY}, q);
            wd_start = cycles;
            bus(1, IDX_PROGRAM_COMMAND_LOW, START_KEY, q);
            repeat (2) @(posedge core_clk);
            wait_busy(1'b1);
            wait_busy(1'b0);
            n_compared++;
            if (cycles - wd_start > WD_LIMIT) begin
                mismatches++;
                $display("CHECK FAILED %0t sequence outlasted watchdog", $time);
            end
            for (int i = 0; i < 32; i++) begin
                chk(mem.rom[{fa[11:5], 5'(i)}], ex[i], "page byte");
            end
            bus(0, IDX_PAGE_ADDRESS_LOW, 8'h00, q);
            chk(q, low_of(fa, RESET_NIBBLE), "low readback");
            $display("program %0d done", k);
        end
        summarize();
    end
endmodule : tb_top
bind fpp_ctrl fpp_ctrl_chk chk (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .ram_rd(ram_rd),
    .flash_erase(flash_erase), .flash_write(flash_write), .flash_page(flash_page),
    .flash_byte(flash_byte), .flash_wdata(flash_wdata), .busy(busy));
